// ===== option_cfg_pkg.sv
package option_cfg_pkg;

	////////////////////////////////////////////////////////////////////////////
	// storage and port geometry
	localparam int          BYTE_W       = 8;
	localparam int          ADDR_W       = 2;
	localparam logic [7:0]  OPT_BLANK    = 8'hFF;
	localparam logic [7:0]  DATA_ZERO    = 8'h00;
	localparam logic [1:0]  ADDR_OPT0    = 2'h0;
	localparam logic [1:0]  ADDR_OPT1    = 2'h1;
	localparam logic [1:0]  ADDR_STATUS  = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// byte 0 field positions
	localparam int          B0_PKG_BIT   = 1;
	localparam int          B0_PROT_BIT  = 0;

	////////////////////////////////////////////////////////////////////////////
	// byte 1 field positions
	localparam int          B1_CSS_BIT   = 7;
	localparam int          B1_OSC_HI    = 6;
	localparam int          B1_OSC_LO    = 4;
	localparam int          B1_LVD_HI    = 3;
	localparam int          B1_LVD_LO    = 2;
	localparam int          B1_HALT_BIT  = 1;
	localparam int          B1_WDG_BIT   = 0;

	////////////////////////////////////////////////////////////////////////////
	// status word bit positions
	localparam int          ST_PROT_BIT  = 0;
	localparam int          ST_PROG_BIT  = 1;
	localparam int          ST_MASK_BIT  = 2;

	////////////////////////////////////////////////////////////////////////////
	// main oscillator choices
	typedef enum logic [2:0] {
		OSC_EXT_CLOCK  = 3'b111,
		OSC_INT_RC     = 3'b110,
		OSC_EXT_RC     = 3'b100,
		OSC_LP_RES     = 3'b011,
		OSC_MP_RES     = 3'b010,
		OSC_MS_RES     = 3'b001,
		OSC_HS_RES     = 3'b000
	} osc_sel_t;

	localparam logic [1:0]  OSC_EXT_RC_HI = 2'b10;

	////////////////////////////////////////////////////////////////////////////
	// brownout detector thresholds
	typedef enum logic [1:0] {
		LVD_OFF        = 2'b11,
		LVD_HIGHEST    = 2'b10,
		LVD_MEDIUM     = 2'b01,
		LVD_LOWEST     = 2'b00
	} lvd_sel_t;

	////////////////////////////////////////////////////////////////////////////
	// decoded configuration carried to the consumers
	typedef struct packed {
		logic          pkg_large;
		logic          readout_protect_bit;
		logic          pgm_ext_access_allow;
		logic          data_ext_access_allow;
		logic          css_enable;
		osc_sel_t      main_oscillator_select;
		logic          brownout_enable;
		lvd_sel_t      brownout_threshold_select;
		logic          halt_entry_reset_enable;
		logic          watchdog_type_select;
		logic          watchdog_hw_enable;
	} cfg_t;

	// programming port request
	typedef struct packed {
		logic [1:0]    addr;
		logic [7:0]    wdata;
		logic          wr_en;
		logic          rd_en;
	} prog_req_t;

endpackage : option_cfg_pkg

// ===== option_byte_config_decoder.sv
// Functional notes
// - two user configuration bytes select the hardware options
// - bytes live outside the memory map, reachable only in programming mode
// - blank non-volatile bytes read FFh as shipped
// - byte 0 bit 1: 0 small package, 1 large package
// - byte 0 bit 0: 1 blocks external program memory access
// - clearing protect bit erases program memory with latched values
// - protection covers program memory only, never data memory
// - byte 1 bit 7: 0 enables clock security supervisor
// - byte 1 bits 6:4 select the main oscillator type
// - byte 1 bits 3:2: off, highest, medium or lowest detector threshold
// - byte 1 bit 1: 1 resets on halt entry while watchdog active
// - byte 1 bit 0: 0 hardware watchdog, 1 software watchdog
// - mask variants fix both bytes in hardware
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/100ps

module option_byte_config_decoder
	import option_cfg_pkg::*;
#(
	parameter bit         MASK_ROM  = 1'b0,
	parameter logic [7:0] MASK_OPT0 = OPT_BLANK,
	parameter logic [7:0] MASK_OPT1 = OPT_BLANK
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              nvm_fresh,
	input  wire logic              prog_mode_pin,
	input  wire prog_req_t         prog_req,
	output logic [BYTE_W-1:0]      prog_rdata,
	input  wire logic              halt_entry,
	input  wire logic              watchdog_active,
	output logic                   halt_reset_req,
	output logic                   pgm_erase_pulse,
	output cfg_t                   cfg
);

	////////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic [BYTE_W-1:0] nv0;
		logic [BYTE_W-1:0] nv1;
		logic [BYTE_W-1:0] sh0;
		logic [BYTE_W-1:0] sh1;
		logic [2:0]        pm_sync;
		logic              pm;
		logic [BYTE_W-1:0] rdata;
		logic              erase;
		cfg_t              cfg;
	} state_t;

	state_t st_reg;
	state_t st_next;

	////////////////////////////////////////////////////////////////////////////
	// oscillator decode, 10x both mean external rc
	function automatic osc_sel_t osc_decode(input logic [2:0] code);
		osc_sel_t res;
		res = osc_sel_t'(code);
		if (code[2:1] == OSC_EXT_RC_HI) begin
			res = OSC_EXT_RC;
		end
		return res;
	endfunction : osc_decode

	////////////////////////////////////////////////////////////////////////////
	// decode of the latched bytes
	function automatic cfg_t cfg_decode(input logic [7:0] b0, input logic [7:0] b1);
		cfg_t c;
		c.pkg_large                 = b0[B0_PKG_BIT];
		c.readout_protect_bit       = b0[B0_PROT_BIT];
		c.pgm_ext_access_allow      = ~b0[B0_PROT_BIT];
		c.data_ext_access_allow     = 1'b1;
		c.css_enable                = ~b1[B1_CSS_BIT];
		c.main_oscillator_select    = osc_decode(b1[B1_OSC_HI:B1_OSC_LO]);
		c.brownout_threshold_select = lvd_sel_t'(b1[B1_LVD_HI:B1_LVD_LO]);
		c.brownout_enable           = (b1[B1_LVD_HI:B1_LVD_LO] != LVD_OFF);
		c.halt_entry_reset_enable   = b1[B1_HALT_BIT];
		c.watchdog_type_select      = b1[B1_WDG_BIT];
		c.watchdog_hw_enable        = ~b1[B1_WDG_BIT];
		return c;
	endfunction : cfg_decode

	////////////////////////////////////////////////////////////////////////////
	// next state
	logic              prog_ok;
	logic [BYTE_W-1:0] src0;
	logic [BYTE_W-1:0] src1;

	always_comb begin
		st_next = st_reg;
		st_next.erase = 1'b0;
		st_next.rdata = DATA_ZERO;

		// programming mode pin, accepted once stages two and three agree
		st_next.pm_sync = {st_reg.pm_sync[1:0], prog_mode_pin};
		if (st_reg.pm_sync[1] == st_reg.pm_sync[2]) begin
			st_next.pm = st_reg.pm_sync[2];
		end

		prog_ok = st_reg.pm;

		// mask parts take fixed bytes instead of the storage
		src0 = MASK_ROM ? MASK_OPT0 : st_reg.nv0;
		src1 = MASK_ROM ? MASK_OPT1 : st_reg.nv1;

		// programming port, reads answer in the next cycle
		if (prog_ok && prog_req.rd_en) begin
			unique case (prog_req.addr)
				ADDR_OPT0: st_next.rdata = src0;
				ADDR_OPT1: st_next.rdata = src1;
				ADDR_STATUS: begin
					st_next.rdata[ST_PROT_BIT] = st_reg.sh0[B0_PROT_BIT];
					st_next.rdata[ST_PROG_BIT] = st_reg.pm;
					st_next.rdata[ST_MASK_BIT] = MASK_ROM;
				end
				default: st_next.rdata = DATA_ZERO;
			endcase
		end

		if (prog_ok && prog_req.wr_en && !MASK_ROM) begin
			unique case (prog_req.addr)
				ADDR_OPT0: begin
					st_next.nv0 = prog_req.wdata;
					if (st_reg.nv0[B0_PROT_BIT] && !prog_req.wdata[B0_PROT_BIT]) begin
						st_next.erase = 1'b1;
					end
				end
				ADDR_OPT1: st_next.nv1 = prog_req.wdata;
				default: st_next.nv0 = st_reg.nv0;
			endcase
		end

		if (!rst_n) begin
			if (nvm_fresh) begin
				st_next.nv0 = OPT_BLANK;
				st_next.nv1 = OPT_BLANK;
			end
			st_next.sh0     = MASK_ROM ? MASK_OPT0 : (nvm_fresh ? OPT_BLANK : st_reg.nv0);
			st_next.sh1     = MASK_ROM ? MASK_OPT1 : (nvm_fresh ? OPT_BLANK : st_reg.nv1);
			st_next.cfg     = cfg_decode(st_next.sh0, st_next.sh1);
			st_next.pm_sync = 3'b000;
			st_next.pm      = 1'b0;
			st_next.rdata   = DATA_ZERO;
			st_next.erase   = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register
	always_ff @(posedge mclk) begin
		st_reg <= st_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign prog_rdata      = st_reg.rdata;
	assign pgm_erase_pulse = st_reg.erase;
	assign cfg             = st_reg.cfg;
	assign halt_reset_req  = halt_entry & watchdog_active & st_reg.cfg.halt_entry_reset_enable;

endmodule : option_byte_config_decoder

// ===== option_cfg_chk_asserts.sv
`timescale 1ns/100ps
module option_cfg_chk
	import option_cfg_pkg::*;
(
	input wire logic              mclk,
	input wire logic              rst_n,
	input wire prog_req_t         prog_req,
	input wire logic [BYTE_W-1:0] prog_rdata,
	input wire logic              halt_entry,
	input wire logic              watchdog_active,
	input wire logic              halt_reset_req,
	input wire logic              pgm_erase_pulse,
	input wire cfg_t              cfg
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	halt_req_a: assert property (halt_reset_req ==
		(halt_entry && watchdog_active && cfg.halt_entry_reset_enable)) else $error("halt reset");
	cfg_hold_a: assert property ($past(rst_n) |-> $stable(cfg))
		else $error("cfg moved");
	prot_map_a: assert property (cfg.pgm_ext_access_allow != cfg.readout_protect_bit)
		else $error("protect map");
	data_open_a: assert property (cfg.data_ext_access_allow)
		else $error("data protected");
	lvd_map_a: assert property (cfg.brownout_enable == (cfg.brownout_threshold_select != LVD_OFF))
		else $error("lvd enable");
	wdg_map_a: assert property (cfg.watchdog_hw_enable != cfg.watchdog_type_select)
		else $error("wdg type");
	osc_code_a: assert property (cfg.main_oscillator_select != 3'b101)
		else $error("osc code");
	rdata_idle_a: assert property (!$past(prog_req.rd_en) |-> prog_rdata == DATA_ZERO)
		else $error("rdata idle");
	erase_pulse_a: assert property (pgm_erase_pulse |-> $past(prog_req.wr_en &&
		prog_req.addr == ADDR_OPT0 && !prog_req.wdata[0]) ##1 !pgm_erase_pulse) else $error("erase");
	cover property (pgm_erase_pulse);
	cover property (halt_reset_req);
	cover property (prog_rdata != DATA_ZERO);
endmodule : option_cfg_chk
bind option_byte_config_decoder option_cfg_chk chk_u(.mclk, .rst_n, .prog_req, .prog_rdata,
	.halt_entry, .watchdog_active, .halt_reset_req, .pgm_erase_pulse, .cfg);

// ===== prog_tool_model.sv
`timescale 1ns/100ps
module prog_tool_model
	import option_cfg_pkg::*;
(
	input wire logic       mclk,
	input wire logic [7:0] rdata,
	output prog_req_t      req
);
	initial req = '0;
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk) req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk) req <= '{a, ~d, 1'b0, 1'b0};
	endtask : wr
	task rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge mclk) req <= '{a, 8'h00, 1'b1 ^ 1'b1, 1'b1};
		@(posedge mclk) req <= '{a, 8'h5A, 1'b0, 1'b0};
		#1 d = rdata;
	endtask : rd
endmodule : prog_tool_model

// ===== test_option_byte_config_decoder.sv
`timescale 1ns/100ps
module test_option_byte_config_decoder
	import option_cfg_pkg::*;
;
	logic      mclk = 0, rst_n = 0, nvm_fresh = 1, pin = 0, halt = 0, wdog = 0, hreq, erase;
	prog_req_t req;
	logic[7:0] rdata, b0, b1, d, old0, rdata_m;
	logic      hreq_m, erase_m;
	cfg_t      cfg, exp, cfg_m;
	int        num_errors = 0, num_checks = 0, cyc = 0;
	always #5 mclk = ~mclk;
	prog_tool_model tool_u(.mclk(mclk), .rdata(rdata), .req(req));
	option_byte_config_decoder dut_u(.mclk(mclk), .rst_n(rst_n), .nvm_fresh(nvm_fresh),
		.prog_mode_pin(pin), .prog_req(req), .prog_rdata(rdata), .halt_entry(halt),
		.watchdog_active(wdog), .halt_reset_req(hreq), .pgm_erase_pulse(erase), .cfg(cfg));
	option_byte_config_decoder #(.MASK_ROM(1'b1), .MASK_OPT0(8'hFD), .MASK_OPT1(8'h5A)) dut_m(
		.mclk(mclk), .rst_n(rst_n), .nvm_fresh(nvm_fresh), .prog_mode_pin(pin),
		.prog_req(req), .prog_rdata(rdata_m), .halt_entry(halt), .watchdog_active(wdog),
		.halt_reset_req(hreq_m), .pgm_erase_pulse(erase_m), .cfg(cfg_m));
	////////////////////////////////////////////////////////////////////////////
	function automatic cfg_t dec(input logic [7:0] a, input logic [7:0] b);
		return '{a[1], a[0], !a[0], 1'b1, !b[7], osc_sel_t'(b[6:5] == 2'b10 ? 3'b100 : b[6:4]),
			b[3:2] != 2'b11, lvd_sel_t'(b[3:2]), b[1], b[0], !b[0]};
	endfunction : dec
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task close_out;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : close_out
	task rst(input logic f);
		@(posedge mclk);
		rst_n <= 0;
		nvm_fresh <= f;
		repeat (16) @(posedge mclk);
		rst_n <= 1;
		repeat (6) @(posedge mclk);
	endtask : rst
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h9d39_b315));
		rst(1);
		exp = dec(OPT_BLANK, OPT_BLANK);
		chk("blank", cfg, exp);
		chk("mask", cfg_m, dec(8'hFD, 8'h5A));
		tool_u.rd(ADDR_OPT0, d);
		chk("closed", d, DATA_ZERO);
		pin <= 1;
		repeat (6) @(posedge mclk);
		tool_u.rd(2'h3, d);
		chk("unmapped", d, DATA_ZERO);
		old0 = OPT_BLANK;
		for (int i = 0; i < 32; i++) begin
			b0 = 8'hFC | 8'($urandom);
			b1 = {1'($urandom), 3'(i), 2'(i >> 3), 2'($urandom)};
			tool_u.wr(ADDR_OPT0, b0);
			#1 chk("erase", erase, old0[0] & !b0[0]);
			tool_u.wr(ADDR_OPT1, b1);
			chk("hold", cfg, exp);
			tool_u.rd(ADDR_OPT0, d);
			chk("rd0", d, b0);
			tool_u.rd(ADDR_OPT1, d);
			chk("rd1", d, b1);
			rst(0);
			exp = dec(b0, b1);
			chk("cfg", cfg, exp);
			tool_u.rd(ADDR_STATUS, d);
			chk("status", d, {5'h00, 1'b0, 1'b1, b0[0]});
			halt <= 1'($urandom);
			wdog <= 1'($urandom);
			#2 chk("halt", hreq, halt & wdog & b1[1]);
			old0 = b0;
		end
		chk("mask hold", cfg_m, dec(8'hFD, 8'h5A));
		close_out();
	end
endmodule : test_option_byte_config_decoder
